// >>> rtl/csr_bank_pkg.sv
package csr_bank_pkg;

  // ==========================================================
  // Access widths
  localparam int DATA_W = 32;
  localparam int OFF_W = 16;
  localparam int PORT_FIELD_W = 8;
  localparam int DESTID_W = 16;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [OFF_W-1:0] OFF_DEV_ID = 16'h0000;
  localparam logic [OFF_W-1:0] OFF_DEV_INFO = 16'h0004;
  localparam logic [OFF_W-1:0] OFF_ASM_ID = 16'h0008;
  localparam logic [OFF_W-1:0] OFF_ASM_INFO = 16'h000c;
  localparam logic [OFF_W-1:0] OFF_PE_FEAT = 16'h0010;
  localparam logic [OFF_W-1:0] OFF_SW_PORT = 16'h0014;
  localparam logic [OFF_W-1:0] OFF_SRC_OP = 16'h0018;
  localparam logic [OFF_W-1:0] OFF_MC_SUPPORT = 16'h0030;
  localparam logic [OFF_W-1:0] OFF_LUT_SIZE = 16'h0034;
  localparam logic [OFF_W-1:0] OFF_MC_INFO = 16'h0038;
  localparam logic [OFF_W-1:0] OFF_HOST_LOCK = 16'h0068;
  localparam logic [OFF_W-1:0] OFF_COMP_TAG = 16'h006c;
  localparam logic [OFF_W-1:0] OFF_ROUTE_DESTID = 16'h0070;
  localparam logic [OFF_W-1:0] OFF_ROUTE_PORT = 16'h0074;
  localparam logic [OFF_W-1:0] OFF_DEFAULT_PORT = 16'h0078;
  localparam logic [OFF_W-1:0] OFF_MC_MASK_CFG = 16'h0080;
  localparam logic [OFF_W-1:0] OFF_MC_DEST_CFG = 16'h0084;
  localparam logic [OFF_W-1:0] OFF_MC_ASSOC = 16'h0088;

  // ==========================================================
  // Field positions (little-endian bit index; big-endian bit 31
  // of the register is bit 0 here)
  localparam int ASSOC_CNT_LSB = 16;
  localparam int ASSOC_ING_LSB = 8;
  localparam int ASSOC_LARGE_BIT = 7;
  localparam int ASSOC_CMD_LSB = 5;
  localparam int ASSOC_PRES_BIT = 0;
  localparam int MASK_NUM_LSB = 16;
  localparam int MASK_PORT_LSB = 8;
  localparam int MASK_CMD_LSB = 4;
  localparam int MASK_PRES_BIT = 0;
  localparam int MCD_DEST_LSB = 16;
  localparam int MCD_MASK_LSB = 0;

  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] HOST_UNLOCKED = 16'hffff;
  localparam logic [7:0] PORT_UNMAPPED = 8'hff;
  localparam logic [7:0] PORT_USE_DEFAULT = 8'hde;
  localparam logic [31:0] ASSOC_RESET = 32'h0000_0000;
  localparam logic [1:0] ASSOC_CMD_DEL = 2'h1;
  localparam logic [1:0] ASSOC_CMD_ADD = 2'h2;

  // ==========================================================
  // Capability values; identity words are arbitrary
  localparam logic [31:0] DEV_ID_VALUE = 32'h0a5a_0c3c;
  localparam logic [31:0] DEV_INFO_VALUE = 32'h0000_0001;
  localparam logic [31:0] ASM_ID_VALUE = 32'h0000_0000;
  localparam logic [31:0] ASM_INFO_VALUE = 32'h0000_0100;
  localparam logic [31:0] PE_FEAT_VALUE = 32'h1000_0018;
  // Maintenance read/write issue plus route-any-packet bit
  localparam logic [31:0] SRC_OP_VALUE = 32'h0000_0c04;
  // Simple programming model bit (big-endian bit 0) left clear
  localparam logic [31:0] MC_SUPPORT_VALUE = 32'h0000_0000;
  localparam logic [31:0] LUT_SIZE_VALUE = 32'h0000_0200;

  typedef enum logic [2:0] {
    MC_NOP, MC_READ, MC_ADD, MC_DEL, MC_CLR, MC_ALL
  } mc_cmd_e;

endpackage

// >>> rtl/route_lut.sv
`timescale 1ns/100ps
module route_lut import csr_bank_pkg::*; #(
  parameter int DEPTH = 512,
  parameter int IW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic clr_i,
  // Write side
  input wire logic we_i,
  input wire logic [IW-1:0] waddr_i,
  input wire logic [PORT_FIELD_W-1:0] wdata_i,
  // Two read sides
  input wire logic [IW-1:0] ra_addr_i,
  output logic [PORT_FIELD_W-1:0] ra_data_o,
  input wire logic [IW-1:0] rb_addr_i,
  output logic [PORT_FIELD_W-1:0] rb_data_o
);

  logic [PORT_FIELD_W-1:0] mem_q [DEPTH];

  // Entries start out pointing at the default route
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= PORT_USE_DEFAULT;
      end
    end else if (ce_i) begin
      if (clr_i) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_q[i] <= PORT_USE_DEFAULT;
        end
      end else if (we_i) begin
        mem_q[waddr_i] <= wdata_i;
      end
    end
  end

  assign ra_data_o = mem_q[ra_addr_i];
  assign rb_data_o = mem_q[rb_addr_i];

endmodule

// >>> rtl/csr_bank.sv
// Behaviour
// - All registers 32 bits, whole-word access, bit 0 is MSB, CARs read-only
// - Request through powered-down port: writes ignored, reads return zero
// - Hard reset and self-reset clear all; port reset clears that port
// - Boot loading of reset values only after hard reset
// - Host owner ID write-once; differing later writes ignored
// - Writing the held owner ID releases the lock back to 0xffff
// - Writing 0xffff never takes the lock
// - DestID and output port registers give indirect table access
// - Table write through global pair updates every port's table
// - Table read through global pair returns port 0's entry
// - Default route unmapped after reset; packets using it are discarded
// - Report 512 entries; clearing small-table select accepts 64K IDs
// - Simple multicast model not supported, shown in capability register
// - Mask config adds, removes egress ports and reads mask contents
// - Group association changes only when association register is written
// - Association uses destID and mask from destID config register
// - One destID bound to one mask per operation, no ranges
// - Association: block count, ingress port, large, command, present
// - Advertise maintenance read/write issue and route-any-packet
// - Undefined address reads zero, writes ignored
`timescale 1ns/100ps
module csr_bank import csr_bank_pkg::*; #(
  parameter int N_PORTS = 16,
  parameter int LUT_DEPTH = 512,
  parameter int N_MASKS = 8,
  parameter int PW = $clog2(N_PORTS),
  parameter int MW = $clog2(N_MASKS)
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic self_reset_i,
  // Per-port state
  input wire logic [N_PORTS-1:0] port_reset_i,
  input wire logic [N_PORTS-1:0] port_pwrdn_i,
  input wire logic [N_PORTS-1:0] small_table_select_i,
  // Boot register loading
  input wire logic boot_valid_i,
  input wire logic [OFF_W-1:0] boot_offset_i,
  input wire logic [DATA_W-1:0] boot_wdata_i,
  input wire logic boot_done_i,
  // Maintenance requests
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [PW-1:0] req_port_i,
  input wire logic [OFF_W-1:0] req_offset_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  output logic resp_valid_o,
  output logic [DATA_W-1:0] resp_rdata_o,
  // Route lookup
  input wire logic lk_valid_i,
  input wire logic [PW-1:0] lk_port_i,
  input wire logic [DESTID_W-1:0] lk_destid_i,
  output logic lk_valid_o,
  output logic [PORT_FIELD_W-1:0] lk_egress_o,
  output logic lk_discard_o
);

  localparam int IW = $clog2(LUT_DEPTH);

  function automatic logic hit(input logic en,
                               input logic [OFF_W-1:0] a,
                               input logic [OFF_W-1:0] b);
    return en && (a == b);
  endfunction

  // ==========================================================
  // Write path
  logic boot_window_q;
  logic boot_wr, req_wr, wr_en;
  logic [OFF_W-1:0] woff;
  logic [DATA_W-1:0] wdata;

  // Boot loading only follows hard reset; self-reset does not reopen it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_window_q <= 1'b1;
    end else if (ce_i && (boot_done_i || self_reset_i)) begin
      boot_window_q <= 1'b0;
    end
  end

  assign boot_wr = boot_window_q && boot_valid_i;
  assign req_wr = req_valid_i && req_write_i && !port_pwrdn_i[req_port_i];
  assign wr_en = boot_wr || req_wr;
  assign woff = boot_wr ? boot_offset_i : req_offset_i;
  assign wdata = boot_wr ? boot_wdata_i : req_wdata_i;

  // ==========================================================
  // Host lock, tag, route and default registers
  logic [15:0] host_owner_id_q;
  logic [31:0] comp_tag_q;
  logic [DESTID_W-1:0] route_destid_q;
  logic [PORT_FIELD_W-1:0] default_port_q;
  logic wr_lock;

  assign wr_lock = hit(wr_en, woff, OFF_HOST_LOCK);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_owner_id_q <= HOST_UNLOCKED;
    end else if (ce_i) begin
      if (self_reset_i) begin
        host_owner_id_q <= HOST_UNLOCKED;
      end else if (wr_lock) begin
        if (host_owner_id_q == HOST_UNLOCKED) begin
          host_owner_id_q <= wdata[15:0];
        end else if (wdata[15:0] == host_owner_id_q) begin
          host_owner_id_q <= HOST_UNLOCKED;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      comp_tag_q <= '0;
      route_destid_q <= '0;
      default_port_q <= PORT_UNMAPPED;
    end else if (ce_i) begin
      if (self_reset_i) begin
        comp_tag_q <= '0;
        route_destid_q <= '0;
        default_port_q <= PORT_UNMAPPED;
      end else begin
        if (hit(wr_en, woff, OFF_COMP_TAG)) begin
          comp_tag_q <= wdata;
        end
        if (hit(wr_en, woff, OFF_ROUTE_DESTID)) begin
          route_destid_q <= wdata[DESTID_W-1:0];
        end
        if (hit(wr_en, woff, OFF_DEFAULT_PORT)) begin
          default_port_q <= wdata[PORT_FIELD_W-1:0];
        end
      end
    end
  end

  // ==========================================================
  // Lookup tables, one per port, written together
  logic lut_we;
  logic [PORT_FIELD_W-1:0] lut_ra [N_PORTS];
  logic [PORT_FIELD_W-1:0] lut_rb [N_PORTS];

  assign lut_we = hit(wr_en, woff, OFF_ROUTE_PORT);

  for (genvar p = 0; p < N_PORTS; p++) begin : g_lut
    route_lut #(.DEPTH(LUT_DEPTH)) u_lut (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .ce_i(ce_i),
      .clr_i(self_reset_i || port_reset_i[p]),
      .we_i(lut_we),
      .waddr_i(route_destid_q[IW-1:0]),
      .wdata_i(wdata[PORT_FIELD_W-1:0]),
      .ra_addr_i(route_destid_q[IW-1:0]),
      .ra_data_o(lut_ra[p]),
      .rb_addr_i(lk_destid_i[IW-1:0]),
      .rb_data_o(lut_rb[p])
    );
  end

  // ==========================================================
  // Multicast masks and group table
  logic [31:0] mask_cfg_q, dest_cfg_q, assoc_q;
  logic [N_MASKS-1:0][N_PORTS-1:0] masks_q;
  logic [N_MASKS-1:0] bound_q;
  logic [DESTID_W-1:0] bound_dest_q [N_MASKS];
  logic [MW-1:0] mask_sel, grp_sel;
  logic [PW-1:0] mask_port;
  logic [DESTID_W-1:0] grp_dest;
  logic wr_mask, wr_assoc, association_valid_flag;
  mc_cmd_e mask_cmd;

  assign wr_mask = hit(wr_en, woff, OFF_MC_MASK_CFG);
  assign wr_assoc = hit(wr_en, woff, OFF_MC_ASSOC);
  assign mask_sel = wr_mask ? wdata[MASK_NUM_LSB +: MW]
                            : mask_cfg_q[MASK_NUM_LSB +: MW];
  assign mask_port = wr_mask ? wdata[MASK_PORT_LSB +: PW]
                             : mask_cfg_q[MASK_PORT_LSB +: PW];
  assign mask_cmd = mc_cmd_e'(wdata[MASK_CMD_LSB +: 3]);
  assign grp_sel = dest_cfg_q[MCD_MASK_LSB +: MW];
  assign grp_dest = dest_cfg_q[MCD_DEST_LSB +: DESTID_W];
  assign association_valid_flag = bound_q[grp_sel] && bound_dest_q[grp_sel] == grp_dest;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_cfg_q <= '0;
      dest_cfg_q <= '0;
      masks_q <= '0;
    end else if (ce_i) begin
      if (self_reset_i) begin
        mask_cfg_q <= '0;
        dest_cfg_q <= '0;
        masks_q <= '0;
      end else begin
        if (wr_mask) begin
          mask_cfg_q <= wdata;
          unique case (mask_cmd)
            MC_NOP, MC_READ: ;
            MC_ADD: masks_q[mask_sel][mask_port] <= 1'b1;
            MC_DEL: masks_q[mask_sel][mask_port] <= 1'b0;
            MC_CLR: masks_q[mask_sel] <= '0;
            MC_ALL: masks_q[mask_sel] <= '1;
            default: ;
          endcase
        end
        if (hit(wr_en, woff, OFF_MC_DEST_CFG)) begin
          dest_cfg_q <= wdata;
        end
        for (int p = 0; p < N_PORTS; p++) begin
          if (port_reset_i[p]) begin
            for (int m = 0; m < N_MASKS; m++) begin
              masks_q[m][p] <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Only one destID to one mask per write; block count is stored only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      assoc_q <= ASSOC_RESET;
      bound_q <= '0;
      for (int m = 0; m < N_MASKS; m++) begin
        bound_dest_q[m] <= '0;
      end
    end else if (ce_i) begin
      if (self_reset_i) begin
        assoc_q <= ASSOC_RESET;
        bound_q <= '0;
      end else if (wr_assoc) begin
        assoc_q <= wdata;
        if (wdata[ASSOC_CMD_LSB +: 2] == ASSOC_CMD_ADD) begin
          bound_q[grp_sel] <= 1'b1;
          bound_dest_q[grp_sel] <= grp_dest;
        end else if (wdata[ASSOC_CMD_LSB +: 2] == ASSOC_CMD_DEL
                     && association_valid_flag) begin
          bound_q[grp_sel] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Read path
  logic [DATA_W-1:0] rd_d;

  always_comb begin
    rd_d = '0;
    unique case (req_offset_i)
      OFF_DEV_ID: rd_d = DEV_ID_VALUE;
      OFF_DEV_INFO: rd_d = DEV_INFO_VALUE;
      OFF_ASM_ID: rd_d = ASM_ID_VALUE;
      OFF_ASM_INFO: rd_d = ASM_INFO_VALUE;
      OFF_PE_FEAT: rd_d = PE_FEAT_VALUE;
      OFF_SW_PORT: rd_d = {16'h0, 8'(N_PORTS), 8'(req_port_i)};
      OFF_SRC_OP: rd_d = SRC_OP_VALUE;
      OFF_MC_SUPPORT: rd_d = MC_SUPPORT_VALUE;
      OFF_LUT_SIZE: rd_d = LUT_SIZE_VALUE;
      OFF_MC_INFO: rd_d = {16'h0, 16'(N_MASKS)};
      OFF_HOST_LOCK: rd_d = {16'h0, host_owner_id_q};
      OFF_COMP_TAG: rd_d = comp_tag_q;
      OFF_ROUTE_DESTID: rd_d = {16'h0, route_destid_q};
      OFF_ROUTE_PORT: rd_d = {24'h0, lut_ra[0]};
      OFF_DEFAULT_PORT: rd_d = {24'h0, default_port_q};
      OFF_MC_MASK_CFG: begin
        rd_d = mask_cfg_q;
        rd_d[MASK_PRES_BIT] = masks_q[mask_sel][mask_port];
      end
      OFF_MC_DEST_CFG: rd_d = dest_cfg_q;
      OFF_MC_ASSOC: begin
        rd_d = assoc_q;
        rd_d[ASSOC_PRES_BIT] = association_valid_flag;
      end
      default: rd_d = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resp_valid_o <= 1'b0;
      resp_rdata_o <= '0;
    end else if (ce_i) begin
      resp_valid_o <= req_valid_i;
      if (req_valid_i && !req_write_i && !port_pwrdn_i[req_port_i]) begin
        resp_rdata_o <= rd_d;
      end else begin
        resp_rdata_o <= '0;
      end
    end
  end

  // ==========================================================
  // Route lookup
  logic [PORT_FIELD_W-1:0] lk_eg;

  // With small-table select cleared, wide IDs fold onto the table
  always_comb begin
    lk_eg = lut_rb[lk_port_i];
    if (small_table_select_i[lk_port_i]
        && lk_destid_i >= DESTID_W'(LUT_DEPTH)) begin
      lk_eg = PORT_USE_DEFAULT;
    end
    if (lk_eg == PORT_USE_DEFAULT) begin
      lk_eg = default_port_q;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lk_valid_o <= 1'b0;
      lk_egress_o <= PORT_UNMAPPED;
      lk_discard_o <= 1'b0;
    end else if (ce_i) begin
      lk_valid_o <= lk_valid_i;
      lk_egress_o <= lk_eg;
      lk_discard_o <= lk_valid_i && (lk_eg == PORT_UNMAPPED
                      || port_pwrdn_i[lk_port_i]);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  chk_lock_take: assert property (
    ce_i && !self_reset_i && wr_lock && host_owner_id_q == HOST_UNLOCKED
    && wdata[15:0] != HOST_UNLOCKED |=> host_owner_id_q == $past(wdata[15:0])
  ) else $error("lock not taken");

  chk_lock_hold: assert property (
    ce_i && !self_reset_i && wr_lock && host_owner_id_q != HOST_UNLOCKED
    && wdata[15:0] != host_owner_id_q |=> $stable(host_owner_id_q)
  ) else $error("locked owner changed");

  chk_lock_release: assert property (
    ce_i && wr_lock && host_owner_id_q != HOST_UNLOCKED
    && wdata[15:0] == host_owner_id_q |=> host_owner_id_q == HOST_UNLOCKED
  ) else $error("lock not released");

  chk_ffff_no_lock: assert property (
    ce_i && wr_lock && wdata[15:0] == HOST_UNLOCKED
    && host_owner_id_q == HOST_UNLOCKED |=> host_owner_id_q == HOST_UNLOCKED
  ) else $error("0xffff took lock");

  chk_pwrdn_zero: assert property (
    ce_i && req_valid_i && port_pwrdn_i[req_port_i]
    |=> resp_valid_o && resp_rdata_o == '0
  ) else $error("powered-down read not zero");

  chk_undef_zero: assert property (
    ce_i && req_valid_i && !req_write_i && req_offset_i == 16'h0040
    |=> resp_valid_o && resp_rdata_o == '0
  ) else $error("undefined read not zero");

  chk_lut_port0: assert property (
    ce_i && req_valid_i && !req_write_i && !port_pwrdn_i[req_port_i]
    && req_offset_i == OFF_ROUTE_PORT
    |=> resp_rdata_o == {24'h0, $past(lut_ra[0])}
  ) else $error("table read not from port 0");

  chk_discard: assert property (
    lk_valid_o && lk_egress_o == PORT_UNMAPPED |-> lk_discard_o
  ) else $error("unmapped route not discarded");

  chk_assoc_only: assert property (
    !$stable(bound_q) |-> $past(wr_assoc) || $past(self_reset_i)
  ) else $error("group table changed without write");

  chk_boot_closed: assert property (
    !boot_window_q |=> !boot_window_q
  ) else $error("boot window reopened");

  cov_lock_taken: cover property (
    wr_lock ##1 host_owner_id_q != HOST_UNLOCKED);
  cov_assoc_add: cover property (wr_assoc ##1 association_valid_flag);
  cov_lut_write: cover property (ce_i && lut_we);
  cov_discard: cover property (lk_valid_o && lk_discard_o);

endmodule

// >>> test/maint_master_model.sv
`timescale 1ns/100ps
module maint_master_model import csr_bank_pkg::*; #(
  parameter int PW = 4
) (
  // Clock and answer
  input wire logic clk_i,
  input wire logic resp_valid_i,
  input wire logic [DATA_W-1:0] resp_rdata_i,
  // Request
  output logic req_valid_o,
  output logic req_write_o,
  output logic [PW-1:0] req_port_o,
  output logic [OFF_W-1:0] req_offset_o,
  output logic [DATA_W-1:0] req_wdata_o
);
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_port_o = '0;
    req_offset_o = '0;
    req_wdata_o = '0;
  end

  // ==========================================================
  // One whole-word request; released offset and data lines show the inverse so
  // a stale value is never mistaken for a live one
  task automatic access(input logic wr, input logic [PW-1:0] port,
      input logic [OFF_W-1:0] off, input logic [DATA_W-1:0] wd,
      output logic [DATA_W-1:0] rd, output bit ok);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_port_o = port;
    req_offset_o = off;
    req_wdata_o = wd;
    @(negedge clk_i);
    req_valid_o = 1'b0;
    req_offset_o = ~off;
    req_wdata_o = ~wd;
    ok = (resp_valid_i === 1'b1);
    rd = resp_rdata_i;
  endtask

  // ==========================================================
  // Claim ownership, then read back before initialising
  task automatic claim(input logic [15:0] id,
      output logic [DATA_W-1:0] rd, output bit ok);
    bit ok1;
    access(1'b1, '0, OFF_HOST_LOCK, {16'h0, id}, rd, ok1);
    access(1'b0, '0, OFF_HOST_LOCK, '0, rd, ok);
    ok = ok & ok1;
  endtask
endmodule

// >>> test/tb_csr_bank.sv
`timescale 1ns/100ps
module tb_csr_bank import csr_bank_pkg::*;;
  logic clk_i, rstn_i, self_reset_i, boot_done_i, lk_valid_i, boot_valid_i;
  logic [15:0] port_reset_i, port_pwrdn_i, small_table_select_i;
  logic [15:0] boot_offset_i;
  logic [31:0] boot_wdata_i;
  logic [3:0] lk_port_i;
  logic [15:0] lk_destid_i;
  logic req_valid, req_write, resp_valid_o, lk_valid_o, lk_discard_o;
  logic [3:0] req_port;
  logic [15:0] req_offset;
  logic [31:0] req_wdata, resp_rdata_o, got;
  logic [7:0] lk_egress_o;
  int err_count, check_count;
  bit ok;

  csr_bank csr_bank_i (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .self_reset_i(self_reset_i), .port_reset_i(port_reset_i),
    .port_pwrdn_i(port_pwrdn_i),
    .small_table_select_i(small_table_select_i),
    .boot_valid_i(boot_valid_i), .boot_offset_i(boot_offset_i),
    .boot_wdata_i(boot_wdata_i), .boot_done_i(boot_done_i),
    .req_valid_i(req_valid), .req_write_i(req_write),
    .req_port_i(req_port), .req_offset_i(req_offset),
    .req_wdata_i(req_wdata), .resp_valid_o(resp_valid_o),
    .resp_rdata_o(resp_rdata_o), .lk_valid_i(lk_valid_i),
    .lk_port_i(lk_port_i), .lk_destid_i(lk_destid_i),
    .lk_valid_o(lk_valid_o), .lk_egress_o(lk_egress_o),
    .lk_discard_o(lk_discard_o));
  maint_master_model #(.PW(4)) maint_master_model_i (.clk_i(clk_i),
    .resp_valid_i(resp_valid_o), .resp_rdata_i(resp_rdata_o),
    .req_valid_o(req_valid), .req_write_o(req_write),
    .req_port_o(req_port), .req_offset_o(req_offset),
    .req_wdata_o(req_wdata));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared checks and accesses
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic hang_chk();
    if (!ok) begin
      err_count++;
      $display("CHECK FAILED at %0t: no answer", $time);
      stop_test();
    end
  endtask
  task automatic rd(input logic [3:0] p, input logic [15:0] off,
      input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
    maint_master_model_i.access(1'b0, p, off, '0, got, ok);
    hang_chk();
    chk(got & m, e);
  endtask
  task automatic wr(input logic [3:0] p, input logic [15:0] off,
      input logic [31:0] d);
    maint_master_model_i.access(1'b1, p, off, d, got, ok);
    hang_chk();
    chk(got, 32'h0000_0000);
  endtask
  task automatic look(input logic [3:0] p, input logic [15:0] id,
      input logic [7:0] eg, input logic dis);
    @(negedge clk_i);
    lk_valid_i = 1'b1;
    lk_port_i = p;
    lk_destid_i = id;
    @(negedge clk_i);
    lk_valid_i = 1'b0;
    chk({22'h0, lk_valid_o, lk_discard_o, lk_egress_o}, {24'h2, eg} |
      {23'h0, dis, 8'h00});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset_vals();
    rd(0, OFF_HOST_LOCK, 32'h0000_ffff);
    rd(0, OFF_MC_ASSOC, 32'h0000_0000);
    rd(0, OFF_DEFAULT_PORT, 32'h0000_00ff, 32'h0000_00ff);
    rd(0, OFF_SRC_OP, SRC_OP_VALUE);
    rd(0, OFF_MC_SUPPORT, 32'h0, 32'h8000_0000);
    wr(0, OFF_LUT_SIZE, 32'h0000_0040);
    rd(0, OFF_LUT_SIZE, 32'h0000_0200);
  endtask
  task automatic t_lock();
    maint_master_model_i.claim(16'h0005, got, ok);
    hang_chk();
    chk(got, 32'h0000_0005);
    wr(0, OFF_HOST_LOCK, 32'h0000_0007);
    rd(0, OFF_HOST_LOCK, 32'h0000_0005);
    wr(0, OFF_HOST_LOCK, 32'h0000_0005);
    rd(0, OFF_HOST_LOCK, 32'h0000_ffff);
    wr(0, OFF_HOST_LOCK, 32'h0000_ffff);
    wr(0, OFF_HOST_LOCK, 32'h0000_0009);
    rd(0, OFF_HOST_LOCK, 32'h0000_0009);
  endtask
  task automatic t_lut();
    wr(0, OFF_ROUTE_DESTID, 32'h0000_0010);
    wr(0, OFF_ROUTE_PORT, 32'h0000_0003);
    rd(0, OFF_ROUTE_PORT, 32'h0000_0003, 32'h0000_00ff);
    look(2, 16'h0010, 8'h03, 1'b0);
    look(0, 16'h0011, 8'hff, 1'b1);
    look(0, 16'h0210, 8'hff, 1'b1);
    // Wide IDs fold onto the low index bits once the small table is off
    small_table_select_i = 16'hfffb;
    look(2, 16'h0210, 8'h03, 1'b0);
    small_table_select_i = 16'hffff;
    // Port reset wipes only port 0's table; reads come from port 0
    @(negedge clk_i);
    port_reset_i = 16'h0001;
    @(negedge clk_i);
    port_reset_i = 16'h0000;
    rd(0, OFF_ROUTE_PORT, 32'h0000_00de, 32'h0000_00ff);
    look(2, 16'h0010, 8'h03, 1'b0);
  endtask
  task automatic t_pwrdn();
    wr(0, OFF_COMP_TAG, 32'h1234_5678);
    port_pwrdn_i = 16'h0002;
    wr(1, OFF_COMP_TAG, 32'h0bad_0bad);
    rd(1, OFF_COMP_TAG, 32'h0000_0000);
    port_pwrdn_i = 16'h0000;
    rd(1, OFF_COMP_TAG, 32'h1234_5678);
    wr(0, 16'h0040, 32'hffff_ffff);
    rd(0, 16'h0040, 32'h0000_0000);
  endtask
  task automatic t_mcast();
    wr(0, OFF_MC_MASK_CFG, 32'h0001_0220);
    wr(0, OFF_MC_MASK_CFG, 32'h0001_0210);
    rd(0, OFF_MC_MASK_CFG, 32'h0000_0001, 32'h0000_0001);
    wr(0, OFF_MC_MASK_CFG, 32'h0001_0230);
    wr(0, OFF_MC_MASK_CFG, 32'h0001_0210);
    rd(0, OFF_MC_MASK_CFG, 32'h0000_0000, 32'h0000_0001);
    wr(0, OFF_MC_DEST_CFG, 32'h0020_0001);
    rd(0, OFF_MC_ASSOC, 32'h0000_0000, 32'h0000_0001);
    wr(0, OFF_MC_ASSOC, 32'h0003_0040);
    rd(0, OFF_MC_ASSOC, 32'h0003_0001, 32'hffff_0001);
    wr(0, OFF_MC_DEST_CFG, 32'h0021_0001);
    rd(0, OFF_MC_ASSOC, 32'h0000_0000, 32'h0000_0001);
    wr(0, OFF_MC_DEST_CFG, 32'h0020_0001);
    wr(0, OFF_MC_ASSOC, 32'h0003_0020);
    rd(0, OFF_MC_ASSOC, 32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic t_self_reset();
    @(negedge clk_i);
    self_reset_i = 1'b1;
    @(negedge clk_i);
    self_reset_i = 1'b0;
    rd(0, OFF_HOST_LOCK, 32'h0000_ffff);
    look(2, 16'h0010, 8'hff, 1'b1);
  endtask
  task automatic t_boot();
    wr(0, OFF_MC_DEST_CFG, 32'h0020_0001);
    // Hard reset in mid-run reopens the boot window
    @(negedge clk_i);
    rstn_i = 1'b0;
    boot_done_i = 1'b0;
    @(negedge clk_i);
    rstn_i = 1'b1;
    rd(0, OFF_MC_DEST_CFG, 32'h0000_0000);
    @(negedge clk_i);
    boot_valid_i = 1'b1;
    boot_offset_i = OFF_COMP_TAG;
    boot_wdata_i = 32'h0000_b007;
    @(negedge clk_i);
    boot_valid_i = 1'b0;
    boot_done_i = 1'b1;
    rd(0, OFF_COMP_TAG, 32'h0000_b007);
    @(negedge clk_i);
    boot_valid_i = 1'b1;
    boot_wdata_i = 32'h0000_0bad;
    @(negedge clk_i);
    boot_valid_i = 1'b0;
    rd(0, OFF_COMP_TAG, 32'h0000_b007);
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0;
    self_reset_i = 1'b0;
    boot_done_i = 1'b0;
    lk_valid_i = 1'b0;
    lk_port_i = '0;
    lk_destid_i = '0;
    port_reset_i = '0;
    port_pwrdn_i = '0;
    small_table_select_i = 16'hffff;
    boot_valid_i = 1'b0;
    boot_offset_i = '0;
    boot_wdata_i = '0;
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    boot_done_i = 1'b1;
    t_reset_vals();
    t_lock();
    t_lut();
    t_pwrdn();
    t_mcast();
    t_self_reset();
    t_boot();
    stop_test();
  end
endmodule
